// [hw/plm_core.sv]
// sum-of-products logic array with eight macrocells and an apb register port
//
// What this block does
// - power-up reset clears every macrocell register, so registered outputs show high
// - preload forces any chosen macrocell register to high or low
// - 64-bit user signature stays readable and writable, secured or not
// - security bit immediately blocks fuse verify reads and register preload
// - pins not driven keep their last level; external drive overrides unless the device drives the pin
// - eight macrocells: registered, combinatorial i/o, combinatorial output or input
// - one device-wide mode: registered, complex or simple
// - power-down pin puts device in standby; release resumes operation, with auto standby on only at the next input transition
// - auto standby when inputs idle; any input transition wakes the device
// - registered mode is forced whenever any macrocell uses its register
// - registered cell captures eight-term sum on clock pin rise; output enable pin gates it
// - combinatorial cell in registered mode: seven-term sum, one term as enable
// - a cell set as input keeps its driver off, except outer cells in complex mode and center cells in simple mode
// - complex mode: seven-term sum, term enable; outer cells have no pin feedback
// - simple mode: eight-term sum, no enable term; center cells always outputs
`timescale 1ns/10ps
module plm_core (
	input wire logic clk,
	input wire logic rstn,
	input wire plm_pkg::plm_apb_req_s apb_req,
	output plm_pkg::plm_apb_rsp_s apb_rsp,
	input wire logic [plm_pkg::NUM_IN-1:0] in_pin,
	input wire logic [plm_pkg::NUM_IN-1:0] in_drv,
	input wire logic clk_pin,
	input wire logic oe_pin_n,
	input wire logic pd_pin,
	input wire logic [plm_pkg::NUM_MC-1:0] io_in,
	input wire logic [plm_pkg::NUM_MC-1:0] io_drv,
	output logic [plm_pkg::NUM_MC-1:0] io_out,
	output logic [plm_pkg::NUM_MC-1:0] io_oe,
	output logic standby
);
	import plm_pkg::*;

	function automatic logic pterm(input logic [NUM_COL-1:0] row, input logic [NUM_COL-1:0] col);
		pterm = (row != '0) && ((row & ~col) == '0);
	endfunction

	function automatic plm_mode_e eff_mode(input logic [1:0] cfg, input logic [NUM_MC-1:0] rsel);
		if (rsel != '0) begin
			eff_mode = MODE_REG;
		end else if (cfg == MODE_CPLX) begin
			eff_mode = MODE_CPLX;
		end else if (cfg == MODE_SMPL) begin
			eff_mode = MODE_SMPL;
		end else begin
			eff_mode = MODE_REG;
		end
	endfunction

	// configuration and bus state
	logic [1:0] mode_cfg, next_mode_cfg;
	logic auto_pd, next_auto_pd, secured, next_secured;
	logic [NUM_MC-1:0] reg_sel, next_reg_sel, in_sel, next_in_sel;
	logic [5:0] fuse_idx, next_fuse_idx;
	logic [NUM_COL-1:0] fuse [NUM_ROW];
	logic [NUM_COL-1:0] next_fuse [NUM_ROW];
	plm_apb_rsp_s next_rsp;
	logic acc, ack_now, wr_fire, pl_wr, sig_we;
	logic [31:0] sig_rdata;
	// core state
	plm_pwr_e pstate, next_pstate;
	logic [6:0] por_cnt, next_por_cnt;
	logic [2:0] idle_cnt, next_idle_cnt;
	logic [NUM_MC-1:0] q, next_q, io_keep, next_io_keep, next_io_out, next_io_oe;
	logic [NUM_IN-1:0] in_keep, next_in_keep;
	logic clk_pin_d, next_clk_pin_d, next_standby, trans, cap;
	// array decode
	plm_mode_e mode;
	logic [NUM_COL-1:0] cols;
	logic [NUM_ROW-1:0] pt;
	logic [NUM_MC-1:0] fb, sum8, sum7, oe_pt, in_sel_eff, mc_out, mc_oe;

	plm_sigmem u_sig (
		.clk(clk),
		.rstn(rstn),
		.we(sig_we),
		.addr(apb_req.paddr[SIG_ADDR_BIT]),
		.wdata(apb_req.pwdata),
		.rdata(sig_rdata)
	);

	// apb slave: one wait state, writes land on the pready edge
	always_comb begin
		acc = apb_req.psel & apb_req.penable;
		ack_now = acc & ~apb_rsp.pready;
		wr_fire = acc & apb_rsp.pready & apb_req.pwrite;
		pl_wr = wr_fire && (apb_req.paddr == OFS_PRELOAD);
		sig_we = wr_fire && (apb_req.paddr == OFS_SIG_LO || apb_req.paddr == OFS_SIG_HI);
		next_rsp = '0;
		next_rsp.pready = ack_now;
		next_mode_cfg = mode_cfg;
		next_auto_pd = auto_pd;
		next_secured = secured;
		next_reg_sel = reg_sel;
		next_in_sel = in_sel;
		next_fuse_idx = fuse_idx;
		next_fuse = fuse;
		if (ack_now) begin
			case (apb_req.paddr)
				OFS_CTRL: next_rsp.prdata = {27'h0, 1'b0, secured, auto_pd, mode_cfg};
				OFS_MCCFG: next_rsp.prdata = {16'h0, in_sel, reg_sel};
				OFS_STATUS: next_rsp.prdata = {19'h0, mode, pstate == PS_POR, secured, standby, q};
				OFS_PRELOAD: next_rsp.prdata = 32'h0000_0000;
				OFS_FUSE_IDX: next_rsp.prdata = {26'h0, fuse_idx};
				OFS_FUSE_LO: next_rsp.prdata = secured ? 32'h0000_0000 : fuse[fuse_idx][31:0];
				OFS_FUSE_HI: next_rsp.prdata = secured ? 32'h0000_0000 : {24'h0, fuse[fuse_idx][39:32]};
				OFS_SIG_LO, OFS_SIG_HI: next_rsp.prdata = sig_rdata;
				default: next_rsp.pslverr = 1'b1;
			endcase
			if (apb_req.pwrite) begin
				next_rsp.prdata = 32'h0000_0000;
			end
		end
		if (wr_fire) begin
			case (apb_req.paddr)
				OFS_CTRL: begin
					if (apb_req.pwdata[CTRL_ERASE]) begin
						next_mode_cfg = MODE_RST;
						next_secured = 1'b0;
						next_reg_sel = SEL_RST;
						next_in_sel = SEL_RST;
						for (int r = 0; r < NUM_ROW; r++) begin
							next_fuse[r] = '0;
						end
					end else begin
						next_mode_cfg = apb_req.pwdata[CTRL_MODE_LSB +: 2];
						next_auto_pd = apb_req.pwdata[CTRL_AUTO];
						next_secured = secured | apb_req.pwdata[CTRL_SECURE];
					end
				end
				OFS_MCCFG: begin
					next_reg_sel = apb_req.pwdata[NUM_MC-1:0];
					next_in_sel = apb_req.pwdata[MCCFG_INSEL_LSB +: NUM_MC];
				end
				OFS_FUSE_IDX: next_fuse_idx = apb_req.pwdata[5:0];
				OFS_FUSE_LO: next_fuse[fuse_idx][31:0] = apb_req.pwdata;
				OFS_FUSE_HI: next_fuse[fuse_idx][39:32] = apb_req.pwdata[7:0];
				default: next_fuse_idx = fuse_idx;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			apb_rsp <= '0;
			mode_cfg <= MODE_RST;
			auto_pd <= 1'b0;
			secured <= 1'b0;
			reg_sel <= SEL_RST;
			in_sel <= SEL_RST;
			fuse_idx <= 6'h00;
			for (int r = 0; r < NUM_ROW; r++) begin
				fuse[r] <= '0;
			end
		end else begin
			apb_rsp <= next_rsp;
			mode_cfg <= next_mode_cfg;
			auto_pd <= next_auto_pd;
			secured <= next_secured;
			reg_sel <= next_reg_sel;
			in_sel <= next_in_sel;
			fuse_idx <= next_fuse_idx;
			fuse <= next_fuse;
		end
	end

	// and array, or terms and per-cell output control
	always_comb begin
		mode = eff_mode(mode_cfg, reg_sel);
		for (int i = 0; i < NUM_MC; i++) begin
			fb[i] = (mode == MODE_REG && reg_sel[i]) ? q[i] : io_keep[i];
			if (mode == MODE_CPLX && (i == MC_OUTER_LO || i == MC_OUTER_HI)) begin
				fb[i] = 1'b0;
			end
		end
		cols = {~{fb, in_keep}, {fb, in_keep}};
		for (int r = 0; r < NUM_ROW; r++) begin
			pt[r] = pterm(fuse[r], cols);
		end
		for (int i = 0; i < NUM_MC; i++) begin
			sum8[i] = |pt[i*NUM_PT +: NUM_PT];
			sum7[i] = |pt[i*NUM_PT+1 +: NUM_PT-1];
			oe_pt[i] = pt[i*NUM_PT+OE_PT];
			in_sel_eff[i] = in_sel[i];
			if (mode == MODE_CPLX && (i == MC_OUTER_LO || i == MC_OUTER_HI)) begin
				in_sel_eff[i] = 1'b0;
			end
			if (mode == MODE_SMPL && (i == MC_CTR_LO || i == MC_CTR_HI)) begin
				in_sel_eff[i] = 1'b0;
			end
			mc_out[i] = sum7[i];
			mc_oe[i] = oe_pt[i];
			unique case (mode)
				MODE_REG: begin
					if (reg_sel[i]) begin
						mc_out[i] = ~q[i];
						mc_oe[i] = ~oe_pin_n;
					end
				end
				MODE_CPLX: mc_out[i] = sum7[i];
				MODE_SMPL: begin
					mc_out[i] = sum8[i];
					mc_oe[i] = 1'b1;
				end
			endcase
			if (in_sel_eff[i]) begin
				mc_oe[i] = 1'b0;
			end
		end
	end

	// keepers, register capture, preload and power states
	always_comb begin
		next_in_keep = (in_drv & in_pin) | (~in_drv & in_keep);
		next_io_keep = (io_oe & io_out) | (~io_oe & io_drv & io_in) | (~io_oe & ~io_drv & io_keep);
		trans = (next_in_keep != in_keep) || (((next_io_keep ^ io_keep) & ~io_oe) != '0);
		next_clk_pin_d = clk_pin;
		cap = (pstate == PS_RUN) && clk_pin && !clk_pin_d && (mode == MODE_REG);
		next_pstate = pstate;
		next_por_cnt = por_cnt;
		next_q = q;
		next_idle_cnt = trans ? 3'h0 : ((idle_cnt == IDLE_CYC - 3'h1) ? idle_cnt : idle_cnt + 3'h1);
		unique case (pstate)
			PS_POR: begin
				next_q = '0;
				if (por_cnt == POR_CYC - 7'h01) begin
					next_pstate = PS_RUN;
				end else begin
					next_por_cnt = por_cnt + 7'h01;
				end
			end
			PS_RUN: begin
				if (cap) begin
					next_q = (q & ~reg_sel) | (sum8 & reg_sel);
				end
				if (pl_wr && !secured) begin
					next_q = (next_q & ~apb_req.pwdata[PL_MASK_LSB +: NUM_MC])
						| (apb_req.pwdata[NUM_MC-1:0] & apb_req.pwdata[PL_MASK_LSB +: NUM_MC]);
				end
				if (pd_pin) begin
					next_pstate = PS_STBY;
				end else if (auto_pd && !trans && idle_cnt == IDLE_CYC - 3'h1) begin
					next_pstate = PS_STBY;
				end
			end
			PS_STBY: begin
				if (!pd_pin && (!auto_pd || trans)) begin
					next_pstate = PS_RUN;
				end
			end
			default: next_pstate = PS_POR;
		endcase
		next_standby = (next_pstate == PS_STBY);
		next_io_out = (pstate == PS_STBY) ? io_out : mc_out;
		next_io_oe = (pstate == PS_STBY) ? io_oe : mc_oe;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pstate <= PS_POR;
			por_cnt <= 7'h00;
			idle_cnt <= 3'h0;
			q <= '0;
			in_keep <= '0;
			io_keep <= '0;
			clk_pin_d <= 1'b0;
			io_out <= '0;
			io_oe <= '0;
			standby <= 1'b0;
		end else begin
			pstate <= next_pstate;
			por_cnt <= next_por_cnt;
			idle_cnt <= next_idle_cnt;
			q <= next_q;
			in_keep <= next_in_keep;
			io_keep <= next_io_keep;
			clk_pin_d <= next_clk_pin_d;
			io_out <= next_io_out;
			io_oe <= next_io_oe;
			standby <= next_standby;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_por_low;
		(pstate == PS_POR) |=> (q == '0) && !standby;
	endproperty
	a_por_low: assert property (p_por_low) else $error("register not low in reset interval");
	property p_cap;
		cap && !pl_wr |=> ((q & $past(reg_sel)) == $past(sum8 & reg_sel));
	endproperty
	a_cap: assert property (p_cap) else $error("clock edge did not capture sum");
	property p_preload;
		pl_wr && !secured && pstate == PS_RUN |=> ((q & $past(apb_req.pwdata[15:8]))
			== $past(apb_req.pwdata[7:0] & apb_req.pwdata[15:8]));
	endproperty
	a_preload: assert property (p_preload) else $error("preload value not loaded");
	property p_sec_pl;
		pl_wr && secured && !cap |=> $stable(q);
	endproperty
	a_sec_pl: assert property (p_sec_pl) else $error("preload acted while secured");
	property p_sec_rd;
		ack_now && !apb_req.pwrite && secured && apb_req.paddr == OFS_FUSE_LO |=> apb_rsp.pready && apb_rsp.prdata == '0;
	endproperty
	a_sec_rd: assert property (p_sec_rd) else $error("fuse readable while secured");
	property p_in_oe;
		(in_sel_eff != '0) && pstate != PS_STBY |=> ((io_oe & $past(in_sel_eff)) == '0);
	endproperty
	a_in_oe: assert property (p_in_oe) else $error("input cell driver enabled");
	property p_idle;
		auto_pd && pstate == PS_RUN && !pd_pin && idle_cnt == IDLE_CYC - 3'h1 && !trans |=> standby;
	endproperty
	a_idle: assert property (p_idle) else $error("no standby after idle inputs");
	property p_wake;
		pstate == PS_STBY && trans && !pd_pin |=> !standby && (pstate == PS_RUN);
	endproperty
	a_wake: assert property (p_wake) else $error("transition did not wake device");
	property p_pd;
		pd_pin && pstate == PS_RUN |=> standby [*2] or (standby ##1 !$past(pd_pin));
	endproperty
	a_pd: assert property (p_pd) else $error("power-down pin ignored");
	property p_simple;
		mode == MODE_SMPL && pstate != PS_STBY |=> io_oe[MC_CTR_LO] && io_oe[MC_CTR_HI];
	endproperty
	a_simple: assert property (p_simple) else $error("center cell not driving");
	property p_cplx;
		mode == MODE_CPLX |-> !fb[MC_OUTER_LO] && !fb[MC_OUTER_HI] && (reg_sel == '0);
	endproperty
	a_cplx: assert property (p_cplx) else $error("outer cell fed back in complex mode");
	property p_regmode;
		(reg_sel != '0) |-> (mode == MODE_REG);
	endproperty
	a_regmode: assert property (p_regmode) else $error("register in use outside registered mode");
endmodule

// [hw/plm_pkg.sv]
// package: constants, modes and bus carriers for the logic macrocell block
package plm_pkg;
	localparam int NUM_MC = 8;
	localparam int NUM_IN = 12;
	localparam int NUM_PT = 8;
	localparam int NUM_SIG = NUM_MC + NUM_IN;
	localparam int NUM_COL = 2 * NUM_SIG;
	localparam int NUM_ROW = NUM_MC * NUM_PT;
	localparam int AW = 12;
	localparam int SIG_WORDS = 2;
	// register byte offsets
	localparam logic [AW-1:0] OFS_CTRL = 12'h000;
	localparam logic [AW-1:0] OFS_MCCFG = 12'h004;
	localparam logic [AW-1:0] OFS_STATUS = 12'h008;
	localparam logic [AW-1:0] OFS_PRELOAD = 12'h00C;
	localparam logic [AW-1:0] OFS_FUSE_IDX = 12'h010;
	localparam logic [AW-1:0] OFS_FUSE_LO = 12'h014;
	localparam logic [AW-1:0] OFS_FUSE_HI = 12'h018;
	localparam logic [AW-1:0] OFS_SIG_LO = 12'h020;
	localparam logic [AW-1:0] OFS_SIG_HI = 12'h024;
	// field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_AUTO = 2;
	localparam int CTRL_SECURE = 3;
	localparam int CTRL_ERASE = 4;
	localparam int MCCFG_INSEL_LSB = 8;
	localparam int PL_MASK_LSB = 8;
	localparam int SIG_ADDR_BIT = 2;
	// reset values
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [NUM_MC-1:0] SEL_RST = 8'h00;
	// macrocell positions
	localparam int OE_PT = 0;
	localparam int MC_OUTER_LO = 0;
	localparam int MC_OUTER_HI = NUM_MC - 1;
	localparam int MC_CTR_LO = 3;
	localparam int MC_CTR_HI = 4;
	// timing
	localparam int CLK_NS = 10;
	localparam int POR_NS = 1000;
	localparam logic [6:0] POR_CYC = 7'(POR_NS / CLK_NS);
	localparam int IDLE_NS = 50;
	localparam logic [2:0] IDLE_CYC = 3'((IDLE_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [1:0] {MODE_REG = 2'b00, MODE_CPLX = 2'b01, MODE_SMPL = 2'b10} plm_mode_e;
	typedef enum logic [1:0] {PS_POR = 2'b00, PS_RUN = 2'b01, PS_STBY = 2'b10} plm_pwr_e;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [AW-1:0] paddr;
		logic [31:0] pwdata;
	} plm_apb_req_s;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} plm_apb_rsp_s;
endpackage

// [hw/plm_sigmem.sv]
// little memory holding the user signature words
`timescale 1ns/10ps
module plm_sigmem (
	input wire logic clk,
	input wire logic rstn,
	input wire logic we,
	input wire logic addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);
	import plm_pkg::*;
	logic [31:0] mem [SIG_WORDS];
	logic [31:0] next_rdata;

	// read every cycle, data leaves through a register
	always_comb begin
		next_rdata = mem[addr];
	end

	// storage has no reset, read register does
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= next_rdata;
		end
	end
endmodule

// [testbench/plm_board.sv]
// board model: drives array inputs, clock pin and macrocell pins
`timescale 1ns/10ps
module plm_board (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [11:0] in_val,
	input wire logic [11:0] in_en,
	input wire logic [7:0] io_val,
	input wire logic [7:0] io_en,
	input wire logic clk_req,
	input wire logic [7:0] io_out,
	input wire logic [7:0] io_oe,
	output logic [11:0] in_pin,
	output logic [11:0] in_drv,
	output logic [7:0] io_in,
	output logic [7:0] io_drv,
	output logic clk_pin
);
	logic [6:0] quiet;
	// released inputs flip once and hold, released pins toggle unless the device drives them; board drive beats the device
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			quiet <= 7'h00;
			clk_pin <= 1'b0;
			in_pin <= 12'h000;
			in_drv <= 12'h000;
			io_in <= 8'h00;
			io_drv <= 8'h00;
		end else begin
			quiet <= (quiet == plm_pkg::POR_CYC) ? quiet : quiet + 7'h01;
			clk_pin <= clk_req && (quiet == plm_pkg::POR_CYC) && !clk_pin;
			in_pin <= (in_en & in_val) | (~in_en & in_drv & ~in_pin) | (~in_en & ~in_drv & in_pin);
			in_drv <= in_en;
			io_in <= (io_en & io_val) | (~io_en & io_oe & io_out) | (~io_en & ~io_oe & ~io_in);
			io_drv <= io_en;
		end
	end
endmodule

// [testbench/testbench.sv]
// self-checking bench for the logic macrocell block
`timescale 1ns/10ps
module testbench;
	import plm_pkg::*;
	typedef struct {logic w; logic [AW-1:0] a; logic [31:0] d; logic e;} plm_row_s;
	logic clk, rstn, oe_pin_n, pd_pin, clk_req, clk_pin, standby, rerr;
	logic [11:0] in_val, in_en, in_pin, in_drv;
	logic [7:0] io_val, io_en, io_in, io_drv, io_out, io_oe;
	logic [31:0] rdat;
	plm_apb_req_s req;
	plm_apb_rsp_s rsp;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	// register table: writes carry data, reads carry the expected word
	plm_row_s rows [21] = '{
		'{0, OFS_STATUS, 32'h0000_0400, 0}, '{1, OFS_CTRL, 32'h0000_0010, 0},
		'{1, OFS_MCCFG, 32'h0000_0401, 0}, '{0, OFS_MCCFG, 32'h0000_0401, 0},
		'{1, OFS_SIG_LO, 32'hA5A5_1234, 0}, '{1, OFS_SIG_HI, 32'h0F0F_C3C3, 0},
		'{0, OFS_SIG_LO, 32'hA5A5_1234, 0}, '{0, OFS_SIG_HI, 32'h0F0F_C3C3, 0},
		'{1, OFS_FUSE_IDX, 32'h0, 0}, '{1, OFS_FUSE_LO, 32'h1, 0}, '{0, OFS_FUSE_LO, 32'h1, 0},
		'{1, OFS_FUSE_IDX, 32'h8, 0}, '{1, OFS_FUSE_LO, 32'h2, 0},
		'{1, OFS_FUSE_IDX, 32'h9, 0}, '{1, OFS_FUSE_LO, 32'h4, 0},
		'{1, OFS_FUSE_IDX, 32'h10, 0}, '{1, OFS_FUSE_LO, 32'h1, 0},
		'{0, OFS_PRELOAD, 32'h0, 0}, '{0, 12'h030, 32'h0, 1}, '{1, 12'h030, 32'h1, 1},
		'{0, OFS_MCCFG, 32'h0000_0401, 0}};

	plm_core i_dut (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .in_pin(in_pin),
		.in_drv(in_drv), .clk_pin(clk_pin), .oe_pin_n(oe_pin_n), .pd_pin(pd_pin), .io_in(io_in),
		.io_drv(io_drv), .io_out(io_out), .io_oe(io_oe), .standby(standby));
	plm_board i_board (.clk(clk), .rstn(rstn), .in_val(in_val), .in_en(in_en), .io_val(io_val),
		.io_en(io_en), .clk_req(clk_req), .io_out(io_out), .io_oe(io_oe), .in_pin(in_pin),
		.in_drv(in_drv), .io_in(io_in), .io_drv(io_drv), .clk_pin(clk_pin));

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			stop_test();
		end
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rstn = 1'b0;
		req = '0;
		oe_pin_n = 1'b0;
		pd_pin = 1'b0;
		clk_req = 1'b0;
		in_val = 12'h000;
		in_en = 12'hFFF;
		io_val = 8'h00;
		io_en = 8'h00;
		wait_clk(2);
		rstn <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) begin
				chk(rdat, rows[i].d);
			end
			chk(32'(rerr), 32'(rows[i].e));
		end
		$display("register table test done");
		wait_clk(int'(POR_CYC));
		in_val <= 12'h007;
		wait_clk(5);
		chk(32'(io_out[0]), 32'h1);
		chk({24'h0, io_oe}, 32'h03);
		chk({24'h0, io_out}, 32'h03);
		clk_req <= 1'b1;
		@(posedge clk);
		clk_req <= 1'b0;
		wait_clk(5);
		chk(32'(io_out[0]), 32'h0);
		oe_pin_n <= 1'b1;
		in_val <= 12'h005;
		wait_clk(5);
		chk({24'h0, io_oe}, 32'h00);
		$display("registered mode test done");
		apb(1'b1, OFS_PRELOAD, 32'h0000_0100);
		wait_clk(2);
		chk(32'(io_out[0]), 32'h1);
		apb(1'b1, OFS_PRELOAD, 32'h0000_0101);
		wait_clk(2);
		chk(32'(io_out[0]), 32'h0);
		in_en <= 12'hFFB;
		wait_clk(6);
		chk({24'h0, io_out}, 32'h02);
		in_en <= 12'hFFF;
		$display("preload and keeper test done");
		apb(1'b1, OFS_CTRL, 32'h0000_000A);
		apb(1'b1, OFS_PRELOAD, 32'h0000_0100);
		apb(1'b0, OFS_FUSE_LO, 32'h0);
		chk(rdat, 32'h0);
		chk(32'(io_out[0]), 32'h0);
		apb(1'b0, OFS_SIG_HI, 32'h0);
		chk(rdat, 32'h0F0F_C3C3);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rdat, 32'h0000_0201);
		$display("security test done");
		pd_pin <= 1'b1;
		wait_clk(3);
		chk(32'(standby), 32'h1);
		pd_pin <= 1'b0;
		wait_clk(3);
		chk(32'(standby), 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0000_0004);
		wait_clk(10);
		chk(32'(standby), 32'h1);
		in_val <= 12'h00D;
		wait_clk(4);
		chk(32'(standby), 32'h0);
		$display("power test done");
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		apb(1'b1, OFS_CTRL, 32'h0000_0010);
		apb(1'b1, OFS_CTRL, 32'h0000_0002);
		wait_clk(4);
		chk({24'h0, io_oe}, 32'hFF);
		chk({24'h0, io_out}, 32'h00);
		rstn <= 1'b0;
		@(posedge clk);
		chk({24'h0, io_oe}, 32'h00);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rdat & 32'h0000_04FF, 32'h0000_0400);
		apb(1'b1, OFS_FUSE_LO, 32'h0000_0001);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		wait_clk(4);
		chk({24'h0, io_oe}, 32'h01);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rdat & 32'h0000_1800, 32'h0000_0800);
		apb(1'b1, OFS_CTRL, 32'h0000_0003);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rdat & 32'h0000_1800, 32'h0000_0000);
		$display("mode and reset test done");
		stop_test();
	end
endmodule
